// [logic/metering_pkg.sv]
/*
 * Shared constants of the power metering datapath: widths, saturation
 * limits, divider counts, filter shifts and waveform source codes.
 * Assumes the datapath clock is the master clock of the metering device.
 */
package metering_pkg;

    // ****************************************************************
    // Widths
    // ****************************************************************
    localparam int SAMPLE_W = 20;
    localparam int WORD_W = 24;
    localparam int BYTE_W = 8;
    localparam int WORD_BYTES = 3;
    localparam int GAIN_W = 12;
    localparam int PHASE_W = 6;
    localparam int STATE_W = 40;
    localparam int FRAC_W = 16;

    // ****************************************************************
    // Converter limits and gain
    // ****************************************************************
    localparam logic signed [19:0] CLAMP_POS = 20'h40000;
    localparam logic signed [19:0] CLAMP_NEG = 20'hc0000;
    localparam logic signed [13:0] GAIN_UNITY = 14'sh1000;
    localparam int GAIN_SHIFT = 12;

    // ****************************************************************
    // Timing in master clock cycles, with the clock rate in Hz and the step length in ps
    // ****************************************************************
    localparam int FILTER_DIV = 4;
    localparam int WAVE_BASE_DIV = 128;
    localparam longint MASTER_CLK_HZ = 64'd3579545;
    localparam longint PHASE_STEP_PS = 64'd4470000;
    localparam int STEP_CYCLES = int'((PHASE_STEP_PS * MASTER_CLK_HZ) / 64'd1000000000000);
    localparam int DELAY_TAPS = 64;
    localparam int DELAY_CENTER = 32;

    // ****************************************************************
    // Filter coefficients as right shifts
    // ****************************************************************
    localparam int CH2_WAVEFORM_LOWPASS_SHIFT = 10;
    localparam int POWER_LOWPASS_SHIFT = 14;
    localparam int HPF_SHIFT = 12;

    // ****************************************************************
    // Waveform source codes
    // ****************************************************************
    localparam logic [1:0] SRC_POWER = 2'h0;
    localparam logic [1:0] SRC_CH1 = 2'h2;
    localparam logic [1:0] SRC_CH2 = 2'h3;

endpackage

// [logic/stream_if.sv]
/*
 * Valid/ready word stream between the datapath and its sample buffer.
 * Assumes both ends run on one clock.
 */
`timescale 1ns/1ps
interface stream_if #(parameter int W = 24);
    logic valid;
    logic ready;
    logic [W-1:0] data;
    modport src (output valid, output data, input ready);
    modport snk (input valid, input data, output ready);
endinterface

// [logic/word_buffer.sv]
/*
 * Small FIFO of waveform words with valid/ready on both sides.
 * Assumes one clock and an active-low asynchronous reset.
 */
`timescale 1ns/1ps
module word_buffer #(
    parameter int W = 24,
    parameter int DEPTH = 2
) (
    input wire logic clk,
    input wire logic rst_n,
    stream_if.snk in_s,
    stream_if.src out_s
);
    localparam int AW = (DEPTH > 1) ? $clog2(DEPTH) : 1;

    logic [W-1:0] mem [0:DEPTH-1];
    logic [AW-1:0] wr_r;
    logic [AW-1:0] rd_r;
    logic [AW:0] cnt_r;
    logic push;
    logic pop;

    // ****************************************************************
    // Flags
    // ****************************************************************
    assign in_s.ready = (cnt_r != (AW+1)'(DEPTH));
    assign out_s.valid = (cnt_r != '0);
    assign out_s.data = mem[rd_r];
    assign push = in_s.valid && in_s.ready;
    assign pop = out_s.valid && out_s.ready;

    // ****************************************************************
    // Storage and pointers
    // ****************************************************************
    always_ff @(posedge clk) begin
        if (push) begin
            mem[wr_r] <= in_s.data;
        end
    end

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            wr_r <= '0;
            rd_r <= '0;
            cnt_r <= '0;
        end else begin
            if (push) begin
                wr_r <= (wr_r == AW'(DEPTH - 1)) ? '0 : wr_r + 1'b1;
            end
            if (pop) begin
                rd_r <= (rd_r == AW'(DEPTH - 1)) ? '0 : rd_r + 1'b1;
            end
            if (push && !pop) begin
                cnt_r <= cnt_r + 1'b1;
            end else if (pop && !push) begin
                cnt_r <= cnt_r - 1'b1;
            end
        end
    end
endmodule

// [logic/power_metering_datapath.sv]
/*
 * Signal-processing datapath of an energy meter: gain trim, phase trim,
 * multiplier, power low-pass filter and waveform sample capture with a
 * byte-wide, most significant byte first sample stream.
 * Assumes converter codes and trim settings are synchronous to clk,
 * which is the master clock of the device.
 */
//
// Function
// - Channel 1 scaled by one plus signed 12-bit trim over 4096.
// - Power range smallest at most negative trim, largest at most positive.
// - Source code 10 sends channel 1 samples to waveform output.
// - Power computation never pauses while waveform samples are taken.
// - Two-bit rate select picks one of four waveform sample rates.
// - Interrupt output goes low when a new sample is available.
// - Samples leave as whole bytes, most significant byte first.
// - 20-bit sample sign extended, right-aligned in three bytes.
// - Source code 11 with enable sends channel 2 samples, same scaling.
// - Channel 2 waveform samples pass a 139 Hz single-pole low-pass.
// - Multiplier takes channel 2 unfiltered.
// - Channel 2 delayed by signed 6-bit trim, 4.47 us per step.
// - Negative phase trim shortens channel 2 delay, advancing it.
// - Instantaneous power is channel 1 times channel 2.
// - Second low-pass takes dc of product as active power.
// - Optional channel 1 high-pass; disabled gives no relative phase error.
// - Converter codes saturate at 40000h and C0000h.
// - Fastest waveform rate is master clock divided by 128.
// - Source code 00 sends active power to waveform output.
//
`timescale 1ns/1ps
module power_metering_datapath
    import metering_pkg::*;
#(
    parameter int BUF_DEPTH = 2,
    parameter int LINE_TAPS = DELAY_TAPS
) (
    input wire logic clk,
    input wire logic rst_n,
    input wire logic [SAMPLE_W-1:0] ch1_code,
    input wire logic [SAMPLE_W-1:0] ch2_code,
    input wire logic [GAIN_W-1:0] power_gain_trim,
    input wire logic [PHASE_W-1:0] phase_delay_trim,
    input wire logic [1:0] waveform_source,
    input wire logic [1:0] sample_rate_select,
    input wire logic sample_irq_enable,
    input wire logic ch1_highpass_enable,
    output logic [WORD_W-1:0] active_power,
    output logic [BYTE_W-1:0] wave_byte,
    output logic wave_byte_valid,
    output logic wave_byte_last,
    input wire logic wave_byte_ready,
    output logic irq_n
);

    // ****************************************************************
    // Helpers
    // ****************************************************************
    function automatic logic signed [SAMPLE_W-1:0] clamp_code(
        input logic signed [SAMPLE_W+1:0] x
    );
        logic signed [SAMPLE_W+1:0] lim_pos;
        logic signed [SAMPLE_W+1:0] lim_neg;
        begin
            lim_pos = (SAMPLE_W+2)'(CLAMP_POS);
            lim_neg = (SAMPLE_W+2)'(CLAMP_NEG);
            if (x > lim_pos) begin
                return CLAMP_POS;
            end else if (x < lim_neg) begin
                return CLAMP_NEG;
            end
            return x[SAMPLE_W-1:0];
        end
    endfunction

    function automatic logic signed [STATE_W-1:0] lp_step(
        input logic signed [STATE_W-1:0] y,
        input logic signed [WORD_W-1:0] x,
        input int sh
    );
        logic signed [STATE_W-1:0] xs;
        begin
            xs = {x, {FRAC_W{1'b0}}};
            return y + ((xs - y) >>> sh);
        end
    endfunction

    function automatic logic [WORD_W-1:0] sext_word(
        input logic [SAMPLE_W-1:0] x
    );
        return {{(WORD_W-SAMPLE_W){x[SAMPLE_W-1]}}, x};
    endfunction

    localparam int TAP_AW = $clog2(LINE_TAPS);
    localparam int STEP_AW = $clog2(STEP_CYCLES);

    // ****************************************************************
    // Declarations
    // ****************************************************************
    logic [1:0] div_cnt_r;
    logic filt_tick;
    logic [STEP_AW-1:0] step_cnt_r;
    logic step_tick;
    logic [9:0] rate_cnt_r;
    logic [9:0] rate_last;
    logic rate_tick;
    logic signed [SAMPLE_W-1:0] ch1_sat_r;
    logic signed [SAMPLE_W-1:0] ch2_sat_r;
    logic signed [STATE_W-1:0] dc_state_r;
    logic signed [SAMPLE_W-1:0] ch1_filt;
    logic signed [13:0] gain_factor;
    logic signed [SAMPLE_W+13:0] gain_prod;
    logic signed [SAMPLE_W-1:0] ch1_gain_r;
    logic [2*SAMPLE_W-1:0] line [0:LINE_TAPS-1];
    logic [TAP_AW-1:0] wp_r;
    logic [TAP_AW-1:0] ch2_delay;
    logic signed [SAMPLE_W-1:0] ch1_aligned;
    logic signed [SAMPLE_W-1:0] ch2_aligned;
    logic signed [2*SAMPLE_W-1:0] prod_r;
    logic signed [STATE_W-1:0] power_state_r;
    logic signed [STATE_W-1:0] ch2_waveform_lowpass_state_r;
    logic [WORD_W-1:0] cap_word;
    logic cap_ok;
    logic pend_r;
    logic [WORD_W-1:0] pend_word_r;
    logic [WORD_W-1:0] ser_word_r;
    logic [1:0] ser_cnt_r;
    logic irq_n_r;

    stream_if #(.W(WORD_W)) fill_s ();
    stream_if #(.W(WORD_W)) drain_s ();

    // ****************************************************************
    // Timing dividers
    // ****************************************************************
    // filter update tick
    assign filt_tick = (div_cnt_r == 2'(FILTER_DIV - 1));
    assign step_tick = (step_cnt_r == STEP_AW'(STEP_CYCLES - 1));
    assign rate_last = 10'((WAVE_BASE_DIV << sample_rate_select) - 1);
    assign rate_tick = (rate_cnt_r >= rate_last);

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            div_cnt_r <= '0;
            step_cnt_r <= '0;
        end else begin
            div_cnt_r <= filt_tick ? '0 : div_cnt_r + 1'b1;
            step_cnt_r <= step_tick ? '0 : step_cnt_r + 1'b1;
        end
    end

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            rate_cnt_r <= '0;
        end else begin
            rate_cnt_r <= rate_tick ? '0 : rate_cnt_r + 1'b1;
        end
    end

    // ****************************************************************
    // Input saturation and channel 1 conditioning
    // ****************************************************************
    // saturate converter codes
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            ch1_sat_r <= '0;
            ch2_sat_r <= '0;
        end else if (filt_tick) begin
            ch1_sat_r <= clamp_code((SAMPLE_W+2)'(signed'(ch1_code)));
            ch2_sat_r <= clamp_code((SAMPLE_W+2)'(signed'(ch2_code)));
        end
    end

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            dc_state_r <= '0;
        end else if (filt_tick) begin
            dc_state_r <= lp_step(dc_state_r, WORD_W'(ch1_sat_r), HPF_SHIFT);
        end
    end

    assign ch1_filt = ch1_highpass_enable
        ? clamp_code((SAMPLE_W+2)'(ch1_sat_r)
            - (SAMPLE_W+2)'(signed'(dc_state_r[FRAC_W+SAMPLE_W-1:FRAC_W])))
        : ch1_sat_r;

    assign gain_factor = GAIN_UNITY + 14'(signed'(power_gain_trim));
    assign gain_prod = (SAMPLE_W+14)'(ch1_filt) * (SAMPLE_W+14)'(gain_factor);

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            ch1_gain_r <= '0;
        end else if (filt_tick) begin
            ch1_gain_r <= gain_prod[GAIN_SHIFT+SAMPLE_W-1:GAIN_SHIFT];
        end
    end

    // ****************************************************************
    // Phase alignment
    // ****************************************************************
    // delay line in trim steps
    // Cleared so unwritten taps never reach the filters
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            for (int i = 0; i < LINE_TAPS; i++) begin
                line[i] <= '0;
            end
        end else if (step_tick) begin
            line[wp_r] <= {ch1_gain_r, ch2_sat_r};
        end
    end

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            wp_r <= '0;
        end else if (step_tick) begin
            wp_r <= wp_r + 1'b1;
        end
    end

    assign ch2_delay = TAP_AW'(DELAY_CENTER) + TAP_AW'(phase_delay_trim);
    assign ch1_aligned = line[wp_r - TAP_AW'(DELAY_CENTER)][2*SAMPLE_W-1:SAMPLE_W];
    assign ch2_aligned = (ch2_delay == '0) ? ch2_sat_r
        : line[wp_r - ch2_delay][SAMPLE_W-1:0];

    // ****************************************************************
    // Power computation
    // ****************************************************************
    // instantaneous power product
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            prod_r <= '0;
        end else if (filt_tick) begin
            prod_r <= ch1_aligned * ch2_aligned;
        end
    end

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            power_state_r <= '0;
        end else if (filt_tick) begin
            power_state_r <= lp_step(power_state_r,
                prod_r[2*SAMPLE_W-1:2*SAMPLE_W-WORD_W], POWER_LOWPASS_SHIFT);
        end
    end

    assign active_power = power_state_r[FRAC_W+WORD_W-1:FRAC_W];

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            ch2_waveform_lowpass_state_r <= '0;
        end else if (filt_tick) begin
            ch2_waveform_lowpass_state_r <= lp_step(ch2_waveform_lowpass_state_r, WORD_W'(ch2_sat_r), CH2_WAVEFORM_LOWPASS_SHIFT);
        end
    end

    // ****************************************************************
    // Waveform capture
    // ****************************************************************
    always_comb begin
        cap_word = '0;
        cap_ok = 1'b0;
        unique case (waveform_source)
            SRC_POWER: begin
                cap_word = active_power;
                cap_ok = 1'b1;
            end
            SRC_CH1: begin
                cap_word = sext_word(ch1_gain_r);
                cap_ok = 1'b1;
            end
            SRC_CH2: begin
                cap_word = sext_word(ch2_waveform_lowpass_state_r[FRAC_W+SAMPLE_W-1:FRAC_W]);
                cap_ok = 1'b1;
            end
            default: begin
                cap_word = '0;
                cap_ok = 1'b0;
            end
        endcase
    end

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            pend_r <= 1'b0;
            pend_word_r <= '0;
        end else if (rate_tick && sample_irq_enable && cap_ok) begin
            pend_r <= 1'b1;
            pend_word_r <= cap_word;
        end else if (fill_s.ready) begin
            pend_r <= 1'b0;
        end
    end

    assign fill_s.valid = pend_r;
    assign fill_s.data = pend_word_r;

    word_buffer #(.W(WORD_W), .DEPTH(BUF_DEPTH)) u_buffer (
        .clk(clk),
        .rst_n(rst_n),
        .in_s(fill_s),
        .out_s(drain_s)
    );

    // ****************************************************************
    // Byte serializer
    // ****************************************************************
    assign drain_s.ready = (ser_cnt_r == '0);

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            ser_word_r <= '0;
            ser_cnt_r <= '0;
        end else if (drain_s.valid && drain_s.ready) begin
            ser_word_r <= drain_s.data;
            ser_cnt_r <= 2'(WORD_BYTES);
        end else if (wave_byte_valid && wave_byte_ready) begin
            ser_word_r <= {ser_word_r[WORD_W-BYTE_W-1:0], {BYTE_W{1'b0}}};
            ser_cnt_r <= ser_cnt_r - 1'b1;
        end
    end

    assign wave_byte = ser_word_r[WORD_W-1:WORD_W-BYTE_W];
    assign wave_byte_valid = (ser_cnt_r != '0);
    assign wave_byte_last = (ser_cnt_r == 2'd1);

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            irq_n_r <= 1'b1;
        end else begin
            irq_n_r <= !(drain_s.valid || (ser_cnt_r != '0));
        end
    end

    assign irq_n = irq_n_r;

endmodule

// [testbench/power_metering_checker.sv]
/*
 * Checker of the waveform byte stream and the sample interrupt.
 * Assumes it is bound to the datapath top: one clock, reset active low.
 */
`timescale 1ns/1ps
module power_metering_checker
    import metering_pkg::*;
(
    input wire logic clk,
    input wire logic rst_n,
    input wire logic [1:0] waveform_source,
    input wire logic sample_irq_enable,
    input wire logic [BYTE_W-1:0] wave_byte,
    input wire logic wave_byte_valid,
    input wire logic wave_byte_last,
    input wire logic wave_byte_ready,
    input wire logic irq_n
);
    // ************************************************************
    // Byte position in word
    // ************************************************************
    logic [1:0] idx_r;
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            idx_r <= 2'h0;
        end else if (wave_byte_valid && wave_byte_ready) begin
            idx_r <= wave_byte_last ? 2'h0 : idx_r + 2'h1;
        end
    end
    default clocking @(posedge clk); endclocking
    default disable iff (!rst_n);
    sequence take_mid;
        wave_byte_valid && wave_byte_ready && !wave_byte_last;
    endsequence
    sequence take_end;
        wave_byte_valid && wave_byte_ready && wave_byte_last;
    endsequence
    // ************************************************************
    // Assertions
    // ************************************************************
    a_byte_hold: assert property (
        wave_byte_valid && !wave_byte_ready |=> wave_byte_valid && $stable(wave_byte)
            && $stable(wave_byte_last)) else $error("byte changed before taken");
    a_next_byte: assert property (
        take_mid |=> wave_byte_valid) else $error("next byte late");
    a_word_gap: assert property (
        take_end |=> !wave_byte_valid) else $error("no gap after word");
    a_last_index: assert property (
        wave_byte_valid |-> wave_byte_last == (idx_r == 2'h2)) else $error("last misplaced");
    a_sign_fill: assert property (
        wave_byte_valid && idx_r == 2'h0 && waveform_source[1] |->
            wave_byte[7:4] == {4{wave_byte[3]}}) else $error("sign fill wrong");
    a_irq_valid: assert property (
        wave_byte_valid |-> !irq_n) else $error("irq high with byte offered");
    a_irq_data: assert property (
        !irq_n |-> ##[0:3] (wave_byte_valid || irq_n)) else $error("irq low without data");
    a_irq_rise: assert property (
        $rose(irq_n) |-> !wave_byte_valid) else $error("irq released early");
    a_quiet_off: assert property (
        (!sample_irq_enable || waveform_source == 2'h1)[*6] ##0 irq_n |=> irq_n)
        else $error("sample while disabled");
endmodule

bind power_metering_datapath power_metering_checker u_power_metering_checker (
    .clk(clk),
    .rst_n(rst_n),
    .waveform_source(waveform_source),
    .sample_irq_enable(sample_irq_enable),
    .wave_byte(wave_byte),
    .wave_byte_valid(wave_byte_valid),
    .wave_byte_last(wave_byte_last),
    .wave_byte_ready(wave_byte_ready),
    .irq_n(irq_n)
);

// [testbench/mcu_reader.sv]
/*
 * Host model reading waveform bytes and assembling words.
 * Assumes the bench drives stall to slow the host down.
 */
`timescale 1ns/1ps
module mcu_reader
    import metering_pkg::*;
(
    input wire logic clk,
    input wire logic rst_n,
    input wire logic [BYTE_W-1:0] wave_byte,
    input wire logic wave_byte_valid,
    input wire logic wave_byte_last,
    output logic wave_byte_ready,
    input wire logic stall,
    output logic [WORD_W-1:0] word,
    output logic word_stb
);
    logic [15:0] acc_r;
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            wave_byte_ready <= 1'b0;
        end else begin
            wave_byte_ready <= !stall;
        end
    end
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            acc_r <= 16'h0;
            word <= 24'h0;
            word_stb <= 1'b0;
        end else begin
            word_stb <= 1'b0;
            if (wave_byte_valid && wave_byte_ready) begin
                acc_r <= {acc_r[7:0], wave_byte};
                if (wave_byte_last) begin
                    word <= {acc_r, wave_byte};
                    word_stb <= 1'b1;
                end
            end
        end
    end
endmodule

// [testbench/power_metering_datapath_tb.sv]
/*
 * Self-checking bench of the metering datapath with a host reader model.
 * Assumes the checker is bound by its own file.
 */
`timescale 1ns/1ps
module power_metering_datapath_tb
    import metering_pkg::*;
;
    logic clk, rst_n, sample_irq_enable, ch1_highpass_enable, stall;
    logic [19:0] ch1_code, ch2_code;
    logic [11:0] power_gain_trim;
    logic [5:0] phase_delay_trim;
    logic [1:0] waveform_source, sample_rate_select;
    logic [23:0] active_power, word;
    logic [7:0] wave_byte;
    logic wave_byte_valid, wave_byte_last, wave_byte_ready, irq_n, word_stb;
    logic [31:0] seed;
    logic [23:0] got_q[$];
    int t_q[$];
    int fails, checks, cyc;

    power_metering_datapath u_power_metering_datapath (.clk(clk), .rst_n(rst_n),
        .ch1_code(ch1_code), .ch2_code(ch2_code), .power_gain_trim(power_gain_trim),
        .phase_delay_trim(phase_delay_trim), .waveform_source(waveform_source),
        .sample_rate_select(sample_rate_select), .sample_irq_enable(sample_irq_enable),
        .ch1_highpass_enable(ch1_highpass_enable), .active_power(active_power),
        .wave_byte(wave_byte), .wave_byte_valid(wave_byte_valid),
        .wave_byte_last(wave_byte_last), .wave_byte_ready(wave_byte_ready), .irq_n(irq_n));
    mcu_reader u_mcu_reader (.clk(clk), .rst_n(rst_n), .wave_byte(wave_byte),
        .wave_byte_valid(wave_byte_valid), .wave_byte_last(wave_byte_last),
        .wave_byte_ready(wave_byte_ready), .stall(stall), .word(word), .word_stb(word_stb));

    initial clk = 1'b0;
    always #5 clk = ~clk;
    always @(posedge clk) begin
        cyc <= cyc + 1;
        if (word_stb) begin
            got_q.push_back(word);
            t_q.push_back(cyc);
        end
    end
    // ************************************************************
    // Model and helpers
    // ************************************************************
    function automatic logic [31:0] xorshift(input logic [31:0] s);
        logic [31:0] v;
        v = s ^ (s << 13);
        v = v ^ (v >> 17);
        return v ^ (v << 5);
    endfunction
    function automatic logic [23:0] model_ch1(input int x, input int trim);
        int s;
        s = (x > 262144) ? 262144 : (x < -262144) ? -262144 : x;
        s = (s * (4096 + trim)) >>> 12;
        return 24'(s);
    endfunction
    task automatic compare_word(input string name, input logic [23:0] exp,
        input logic [23:0] got);
        checks++;
        if (got !== exp) begin
            fails++;
            $display("unexpected %s expected %h seen %h", name, exp, got);
        end
    endtask
    task automatic compare_bit(input string name, input logic exp, input logic got);
        compare_word(name, {23'h0, exp}, {23'h0, got});
    endtask
    task automatic get_word(output logic [23:0] w, output int t);
        int n;
        n = 0;
        w = 24'h0;
        t = 0;
        while (got_q.size() == 0 && n < 6000) begin
            @(posedge clk);
            n++;
        end
        if (got_q.size() == 0) begin
            fails++;
            $display("unexpected timeout expected word seen none");
        end else begin
            w = got_q.pop_front();
            t = t_q.pop_front();
        end
    endtask
    task automatic reconfigure(input logic [1:0] src, input logic [1:0] rate);
        int n;
        n = 0;
        sample_irq_enable <= 1'b0;
        repeat (10) @(posedge clk);
        while (irq_n !== 1'b1 && n < 4000) begin
            @(posedge clk);
            n++;
        end
        @(posedge clk);
        waveform_source <= src;
        sample_rate_select <= rate;
        sample_irq_enable <= 1'b1;
        got_q.delete();
        t_q.delete();
    endtask
    task automatic run_power(input logic [11:0] trim, input logic [19:0] c2,
        output logic signed [23:0] ap);
        rst_n <= 1'b0;
        sample_irq_enable <= 1'b0;
        repeat (4) @(posedge clk);
        rst_n <= 1'b1;
        ch1_code <= 20'h20000;
        ch2_code <= c2;
        power_gain_trim <= trim;
        seed = xorshift(seed);
        phase_delay_trim <= seed[5:0];
        @(posedge clk);
        #1 compare_bit("reset_irq_n", 1'b1, irq_n);
        repeat (3000) @(posedge clk);
        #1 ap = active_power;
    endtask
    task automatic test_done;
        $display("checks %0d fails %0d", checks, fails);
        if (fails == 0 && checks > 0) begin
            $display("verification passed");
        end else begin
            $display("verification failed");
        end
        $finish;
    endtask
    // ************************************************************
    // Scenarios
    // ************************************************************
    initial begin
        logic [23:0] w;
        int t0, t1, x, trim;
        logic signed [23:0] ap_hi, ap_mid, ap_lo, ap_neg;
        seed = 32'hdfdd286c;
        {fails, checks, cyc} = {32'd0, 32'd0, 32'd0};
        {rst_n, sample_irq_enable, ch1_highpass_enable, stall} = 4'h0;
        {ch1_code, ch2_code, power_gain_trim, phase_delay_trim} = 58'h0;
        {waveform_source, sample_rate_select} = {SRC_CH1, 2'h0};
        repeat (4) @(posedge clk);
        rst_n <= 1'b1;
        reconfigure(SRC_CH1, 2'h0);
        for (int i = 0; i < 6; i++) begin
            seed = xorshift(seed);
            x = (i == 0) ? 524287 : (i == 1) ? -524288 : $signed(seed[6:0]) * 4096;
            trim = (i < 2) ? 0 : $signed(seed[18:7]);
            ch1_code <= 20'(x);
            power_gain_trim <= 12'(trim);
            repeat (700) @(posedge clk);
            got_q.delete();
            t_q.delete();
            get_word(w, t0);
            compare_word("ch1_sample", model_ch1(x, trim), w);
        end
        for (int r = 0; r < 4; r++) begin
            reconfigure(SRC_CH1, 2'(r));
            get_word(w, t0);
            get_word(w, t1);
            compare_word("sample_spacing", 24'(128 << r), 24'(t1 - t0));
        end
        reconfigure(SRC_CH1, 2'h0);
        stall <= 1'b1;
        repeat (700) @(posedge clk);
        compare_bit("irq_n_stalled", 1'b0, irq_n);
        got_q.delete();
        t_q.delete();
        stall <= 1'b0;
        repeat (300) @(posedge clk);
        compare_bit("burst_words", 1'b1, got_q.size() >= 3);
        while (got_q.size() > 0) begin
            get_word(w, t0);
            compare_word("burst_word", model_ch1(x, trim), w);
        end
        ch2_code <= 20'h20000;
        reconfigure(SRC_CH2, 2'h0);
        repeat (1500) @(posedge clk);
        got_q.delete();
        get_word(w, t0);
        x = $signed(w);
        repeat (6000) @(posedge clk);
        got_q.delete();
        get_word(w, t1);
        compare_bit("ch2_lowpass", 1'b1, x > 0 && x < $signed(w) && $signed(w) < 131072);
        run_power(12'h000, 20'he0000, ap_neg);
        run_power(12'h7ff, 20'h20000, ap_hi);
        run_power(12'h800, 20'h20000, ap_lo);
        run_power(12'h000, 20'h20000, ap_mid);
        compare_bit("power_range", 1'b1, ap_hi > ap_mid && ap_mid > ap_lo && ap_lo > 0);
        compare_bit("power_sign", 1'b1, ap_neg < 0);
        reconfigure(SRC_POWER, 2'h0);
        repeat (500) @(posedge clk);
        got_q.delete();
        get_word(w, t0);
        #1 compare_bit("power_word", 1'b1, $signed(w) > ap_mid && $signed(w) <= $signed(active_power));
        ch1_highpass_enable <= 1'b1;
        reconfigure(SRC_CH1, 2'h0);
        repeat (3000) @(posedge clk);
        got_q.delete();
        get_word(w, t0);
        compare_bit("ch1_highpass", 1'b1, $signed(w) > 0 && $signed(w) < 131072);
        reconfigure(2'h1, 2'h0);
        repeat (1000) @(posedge clk);
        compare_bit("no_source", 1'b1, got_q.size() == 0 && irq_n === 1'b1);
        test_done;
    end
    initial begin
        repeat (90000) @(posedge clk);
        fails++;
        test_done;
    end
endmodule
